// File: pkg/migate_defs.svh
// Register offsets, field positions and reset values of the idle clock gating block
`ifndef MIGATE_DEFS_SVH
`define MIGATE_DEFS_SVH
`define MIG_OFS_ONE     32'h0000_0004
`define MIG_OFS_TWO     32'h0000_0008
`define MIG_OFS_STAT    32'h0000_0010
`define MIG_B_WDT_IDLE  0
`define MIG_B_REF_IDLE  1
`define MIG_B_PER_IDLE  2
`define MIG_B_IF_IDLE   6
`define MIG_B_HOST_IDLE 8
`define MIG_B_TIM_IDLE  9
`define MIG_B_LCD_EN    3
`define MIG_B_HOST_EN   6
`define MIG_B_TIM_EN    7
`define MIG_B_DMA_REQ   8
`define MIG_B_PLL_EN    11
`define MIG_MASK_ONE    32'h0000_0347
`define MIG_MASK_TWO    32'h0000_09C8
`define MIG_RST_ONE     32'h0000_0000
`define MIG_RST_TWO     32'h0000_0100
`endif

// File: pkg/migate_pkg.sv
// Types shared by the idle clock gating block
package migate_pkg;
  typedef struct packed {
    logic bridge;
    logic dma;
    logic tc;
    logic ext_per;
    logic ref_per;
    logic wdt;
    logic pll_out;
    logic timer;
    logic host;
    logic lcd;
  } migate_run_t;
  typedef struct packed {
    logic core_idle;
    logic dsp_idle;
    logic tc_active;
    logic per_idle_ack;
    logic wdt_mode;
    logic dma_req;
    logic host_need;
  } migate_cond_t;
endpackage

// File: hdl/migate_ctrl.sv
// Idle clock gating control for the processor clock domain
`timescale 1ns/1ns
`default_nettype none
`include "migate_defs.svh"

// Notes on behaviour
// - Interface idle bit stops bridge, DMA and traffic clocks when core and DSP idle
// - Peripheral idle bit stops external peripheral clock with core and traffic idle
// - External peripheral clock runs while traffic or core active; stops after ack
// - Reference peripheral idle bit stops reference peripheral clock on core idle
// - Watchdog idle bit stops timer/watchdog clock on core idle
// - Watchdog mode never gates the timer/watchdog clock
// - Reserved bits ignore writes; they read as zero here
// - PLL output clock runs only after software writes enable 1; resets 0
// - DMA request clocking resets 1: clock only on request; else idle-gated
// - Timer enable 0 stops timer clock; 1 runs it, idle-gated by timer idle bit
// - Host port enable 0 stops its clock; 1 runs it under host idle bit
// - LCD enable bit runs or stops the LCD clock; resets 0
// - Timer idle bit stops timer clock with core clock on idle entry
// - Host idle bit makes host clock run only when some function needs it
module migate_ctrl
  import migate_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock, reset, enable
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  wire logic          ce,
  // Register port
  input  wire logic [AW-1:0] addr,
  input  wire logic [31:0]   wdata,
  input  wire logic          we,
  input  wire logic          re,
  output var  logic [31:0]   rdata_q,
  // System conditions
  input  wire migate_cond_t  cond,
  // Peripheral idle handshake
  output var  logic          per_idle_req_q,
  // Clock enables for the downstream gating cells
  output var  migate_run_t   run_q
);

  // Status sits at 0x10, so a narrower address could never reach it
  if (AW < 5 || AW > 32) begin : g_aw_check
    $error("migate_ctrl: AW must be 5..32");
  end

  logic [31:0] one_q;
  logic [31:0] two_q;
  migate_run_t run_d;
  logic        if_stop;
  logic        sel_one;
  logic        sel_two;
  logic        sel_stat;

  assign sel_one  = (addr == AW'(`MIG_OFS_ONE));
  assign sel_two  = (addr == AW'(`MIG_OFS_TWO));
  assign sel_stat = (addr == AW'(`MIG_OFS_STAT));

  // Control registers; reserved positions are masked away on write
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      one_q <= `MIG_RST_ONE;
    end else if (ce && we && sel_one) begin
      one_q <= wdata & `MIG_MASK_ONE;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      two_q <= `MIG_RST_TWO;
    end else if (ce && we && sel_two) begin
      two_q <= wdata & `MIG_MASK_TWO;
    end
  end

  // Read data stand in the cycle after the strobe only; unmapped reads give zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      if (re && sel_one) begin
        rdata_q <= one_q;
      end else if (re && sel_two) begin
        rdata_q <= two_q;
      end else if (re && sel_stat) begin
        rdata_q <= {22'h0, run_q};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  // Interface domain idles only when the DSP core idles too
  assign if_stop = one_q[`MIG_B_IF_IDLE] & cond.core_idle & cond.dsp_idle;

  always_comb begin
    run_d        = '0;
    run_d.bridge = !if_stop;
    run_d.tc     = !if_stop;
    if (two_q[`MIG_B_DMA_REQ]) begin
      run_d.dma = cond.dma_req;
    end else begin
      run_d.dma = !if_stop;
    end
    // Either master active keeps the peripheral clock; stop only after acknowledge
    if (cond.tc_active || !cond.core_idle) begin
      run_d.ext_per = 1'b1;
    end else begin
      run_d.ext_per = !(one_q[`MIG_B_PER_IDLE] && cond.per_idle_ack);
    end
    run_d.ref_per = !(one_q[`MIG_B_REF_IDLE] && cond.core_idle);
    run_d.wdt     = cond.wdt_mode
                  || !(one_q[`MIG_B_WDT_IDLE] && cond.core_idle);
    run_d.pll_out = two_q[`MIG_B_PLL_EN];
    run_d.timer   = two_q[`MIG_B_TIM_EN]
                  && !(one_q[`MIG_B_TIM_IDLE] && cond.core_idle);
    run_d.host    = two_q[`MIG_B_HOST_EN]
                  && (!one_q[`MIG_B_HOST_IDLE] || cond.host_need);
    run_d.lcd     = two_q[`MIG_B_LCD_EN];
  end

  // Enables move only on a rising edge, so a low-phase latch gate never clips a pulse
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= '0;
    end else if (ce) begin
      run_q <= run_d;
    end
  end

  // Request peripheral idle only once both masters have gone quiet
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      per_idle_req_q <= 1'b0;
    end else if (ce) begin
      per_idle_req_q <= one_q[`MIG_B_PER_IDLE] && cond.core_idle
                        && !cond.tc_active;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  property p_if_stop;
    ce && one_q[`MIG_B_IF_IDLE] && cond.core_idle && cond.dsp_idle
      |=> !run_q.bridge && !run_q.tc;
  endproperty
  a_if_stop: assert property (p_if_stop) else $error("bridge or tc clock not stopped");

  property p_if_run;
    ce && !(cond.core_idle && cond.dsp_idle) |=> run_q.bridge && run_q.tc;
  endproperty
  a_if_run: assert property (p_if_run) else $error("bridge or tc clock stopped while active");

  property p_per_idle;
    ce && one_q[`MIG_B_PER_IDLE] && cond.core_idle && !cond.tc_active && cond.per_idle_ack
      |=> !run_q.ext_per;
  endproperty
  a_per_idle: assert property (p_per_idle) else $error("peripheral clock not stopped");

  property p_per_active;
    ce && (cond.tc_active || !cond.core_idle) |=> run_q.ext_per;
  endproperty
  a_per_active: assert property (p_per_active) else $error("peripheral clock off while active");

  property p_ref_idle;
    ce |=> run_q.ref_per == !($past(one_q[`MIG_B_REF_IDLE]) && $past(cond.core_idle));
  endproperty
  a_ref_idle: assert property (p_ref_idle) else $error("reference clock gating wrong");

  property p_wdt_mode;
    ce && cond.wdt_mode |=> run_q.wdt;
  endproperty
  a_wdt_mode: assert property (p_wdt_mode) else $error("watchdog clock gated in watchdog mode");

  property p_wdt_idle;
    ce && !cond.wdt_mode && one_q[`MIG_B_WDT_IDLE] && cond.core_idle |=> !run_q.wdt;
  endproperty
  a_wdt_idle: assert property (p_wdt_idle) else $error("watchdog clock not stopped");

  property p_reserved;
    ce && we |=> (one_q & ~`MIG_MASK_ONE) == 32'h0 && (two_q & ~`MIG_MASK_TWO) == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit took a write");

  property p_pll;
    ce && we && sel_two ##1 ce |=> run_q.pll_out == $past(wdata[`MIG_B_PLL_EN], 2);
  endproperty
  a_pll: assert property (p_pll) else $error("pll output enable not followed");

  property p_dma_req;
    ce && two_q[`MIG_B_DMA_REQ] |=> run_q.dma == $past(cond.dma_req);
  endproperty
  a_dma_req: assert property (p_dma_req) else $error("dma clock not request driven");

  property p_timer;
    ce && !two_q[`MIG_B_TIM_EN] |=> !run_q.timer;
  endproperty
  a_timer: assert property (p_timer) else $error("timer clock runs while disabled");

  property p_timer_idle;
    ce && one_q[`MIG_B_TIM_IDLE] && cond.core_idle |=> !run_q.timer;
  endproperty
  a_timer_idle: assert property (p_timer_idle) else $error("timer clock not idle-gated");

  property p_host;
    ce && two_q[`MIG_B_HOST_EN] && one_q[`MIG_B_HOST_IDLE] |=> run_q.host == $past(cond.host_need);
  endproperty
  a_host: assert property (p_host) else $error("host clock not demand driven");

  property p_host_off;
    ce && !two_q[`MIG_B_HOST_EN] |=> !run_q.host;
  endproperty
  a_host_off: assert property (p_host_off) else $error("host clock runs while disabled");

  property p_lcd;
    ce |=> run_q.lcd == $past(two_q[`MIG_B_LCD_EN]);
  endproperty
  a_lcd: assert property (p_lcd) else $error("lcd clock enable not followed");

  property p_read;
    ce && re && sel_one |=> rdata_q == $past(one_q);
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");

  property p_if_keep;
    ce && !one_q[`MIG_B_IF_IDLE] |=> run_q.bridge && run_q.tc;
  endproperty
  a_if_keep: assert property (p_if_keep) else $error("bridge or tc stopped, bit clear");

  property p_dma_idle;
    ce && !two_q[`MIG_B_DMA_REQ]
      && one_q[`MIG_B_IF_IDLE] && cond.core_idle && cond.dsp_idle |=> !run_q.dma;
  endproperty
  a_dma_idle: assert property (p_dma_idle) else $error("dma clock not idle-gated");

  property p_dma_keep;
    ce && !two_q[`MIG_B_DMA_REQ]
      && !(one_q[`MIG_B_IF_IDLE] && cond.core_idle && cond.dsp_idle) |=> run_q.dma;
  endproperty
  a_dma_keep: assert property (p_dma_keep) else $error("dma clock stopped while needed");

  property p_per_keep;
    ce && !one_q[`MIG_B_PER_IDLE] |=> run_q.ext_per;
  endproperty
  a_per_keep: assert property (p_per_keep) else $error("peripheral clock stopped, bit clear");

  property p_per_wait;
    ce && !cond.per_idle_ack |=> run_q.ext_per;
  endproperty
  a_per_wait: assert property (p_per_wait) else $error("peripheral clock stopped before ack");

  property p_per_req;
    ce |=> per_idle_req_q
           == ($past(one_q[`MIG_B_PER_IDLE]) && $past(cond.core_idle) && !$past(cond.tc_active));
  endproperty
  a_per_req: assert property (p_per_req) else $error("peripheral idle request wrong");

  property p_ref_keep;
    ce && !cond.core_idle |=> run_q.ref_per;
  endproperty
  a_ref_keep: assert property (p_ref_keep) else $error("reference clock stopped while awake");

  property p_wdt_keep;
    ce && !one_q[`MIG_B_WDT_IDLE] |=> run_q.wdt;
  endproperty
  a_wdt_keep: assert property (p_wdt_keep) else $error("watchdog clock stopped, bit clear");

  property p_wdt_awake;
    ce && !cond.core_idle |=> run_q.wdt;
  endproperty
  a_wdt_awake: assert property (p_wdt_awake) else $error("watchdog clock stopped while awake");

  property p_timer_run;
    ce && two_q[`MIG_B_TIM_EN] && !one_q[`MIG_B_TIM_IDLE] |=> run_q.timer;
  endproperty
  a_timer_run: assert property (p_timer_run) else $error("timer clock stopped while enabled");

  property p_timer_keep;
    ce && two_q[`MIG_B_TIM_EN] && !cond.core_idle |=> run_q.timer;
  endproperty
  a_timer_keep: assert property (p_timer_keep) else $error("timer clock stopped while awake");

  property p_host_en;
    ce && two_q[`MIG_B_HOST_EN] && !one_q[`MIG_B_HOST_IDLE] |=> run_q.host;
  endproperty
  a_host_en: assert property (p_host_en) else $error("host clock not following enable");

  property p_host_need;
    ce && two_q[`MIG_B_HOST_EN] && cond.host_need |=> run_q.host;
  endproperty
  a_host_need: assert property (p_host_need) else $error("host clock stopped while needed");

  property p_pll_follow;
    ce |=> run_q.pll_out == $past(two_q[`MIG_B_PLL_EN]);
  endproperty
  a_pll_follow: assert property (p_pll_follow) else $error("pll output enable wrong");

  property p_pll_hold;
    ce && !two_q[`MIG_B_PLL_EN] && !(we && sel_two && wdata[`MIG_B_PLL_EN])
      |=> !two_q[`MIG_B_PLL_EN];
  endproperty
  a_pll_hold: assert property (p_pll_hold) else $error("pll enable set without a write");

  property p_lcd_off;
    ce && !two_q[`MIG_B_LCD_EN] |=> !run_q.lcd;
  endproperty
  a_lcd_off: assert property (p_lcd_off) else $error("lcd clock runs while disabled");

  property p_write_one;
    ce && we && sel_one |=> one_q == ($past(wdata) & `MIG_MASK_ONE);
  endproperty
  a_write_one: assert property (p_write_one) else $error("first register write wrong");

  property p_write_two;
    ce && we && sel_two |=> two_q == ($past(wdata) & `MIG_MASK_TWO);
  endproperty
  a_write_two: assert property (p_write_two) else $error("second register write wrong");

  property p_no_write;
    ce && we && !sel_one && !sel_two |=> $stable(one_q) && $stable(two_q);
  endproperty
  a_no_write: assert property (p_no_write) else $error("unmapped write changed a register");

  property p_read_two;
    ce && re && sel_two |=> rdata_q == $past(two_q);
  endproperty
  a_read_two: assert property (p_read_two) else $error("second register read wrong");

  property p_read_stat;
    ce && re && sel_stat |=> rdata_q == {22'h0, $past(run_q)};
  endproperty
  a_read_stat: assert property (p_read_stat) else $error("status read wrong");

  property p_rdata_idle;
    ce && !re |=> rdata_q == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data stand too long");

  property p_freeze;
    !ce |=> $stable(run_q) && $stable(per_idle_req_q) && $stable(rdata_q)
            && $stable(one_q) && $stable(two_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low");

  c_if_idle: cover property (ce && if_stop ##1 !run_q.bridge);
  c_per_ack: cover property (per_idle_req_q && cond.per_idle_ack ##1 !run_q.ext_per);
  c_dma_req: cover property (two_q[`MIG_B_DMA_REQ] && cond.dma_req ##1 run_q.dma);
  c_wdt_keep: cover property (cond.wdt_mode && one_q[`MIG_B_WDT_IDLE] && cond.core_idle);
  c_freeze: cover property (!ce ##1 !ce);

endmodule
`default_nettype wire

// File: tb/migate_testbench.sv
// Self-checking testbench of the idle clock gating control
`timescale 1ns/1ns
`default_nettype none
`include "migate_defs.svh"
module testbench
  import migate_pkg::*;
();
  logic         ref_clk;
  logic         reset_n;
  logic         ce;
  logic [7:0]   addr;
  logic [31:0]  wdata;
  logic         we;
  logic         re;
  logic [31:0]  rdata_q;
  migate_cond_t cond;
  logic         per_idle_req_q;
  migate_run_t  run_q;
  logic [31:0]  one_m;
  logic [31:0]  two_m;
  logic [31:0]  seen_v;
  logic [31:0]  exp_v;
  migate_run_t  exp_r;
  logic         per_e;
  int           num_errors;
  int           check_count;

  migate_ctrl #(.AW(8)) u_migate_ctrl (
    .ref_clk        (ref_clk),
    .reset_n        (reset_n),
    .ce             (ce),
    .addr           (addr),
    .wdata          (wdata),
    .we             (we),
    .re             (re),
    .rdata_q        (rdata_q),
    .cond           (cond),
    .per_idle_req_q (per_idle_req_q),
    .run_q          (run_q)
  );

  always #2 ref_clk = ~ref_clk;

  // Expected clock-run enables worked out from the register model
  function automatic migate_run_t exp_run(logic [31:0] o, logic [31:0] t, migate_cond_t c);
    migate_run_t r;
    logic        stop_if;
    stop_if   = o[`MIG_B_IF_IDLE] & c.core_idle & c.dsp_idle;
    r.bridge  = !stop_if;
    r.tc      = !stop_if;
    r.dma     = t[`MIG_B_DMA_REQ] ? c.dma_req : !stop_if;
    r.ext_per = (c.tc_active | !c.core_idle) | !(o[`MIG_B_PER_IDLE] & c.per_idle_ack);
    r.ref_per = !(o[`MIG_B_REF_IDLE] & c.core_idle);
    r.wdt     = c.wdt_mode | !(o[`MIG_B_WDT_IDLE] & c.core_idle);
    r.pll_out = t[`MIG_B_PLL_EN];
    r.timer   = t[`MIG_B_TIM_EN] & !(o[`MIG_B_TIM_IDLE] & c.core_idle);
    r.host    = t[`MIG_B_HOST_EN] & (!o[`MIG_B_HOST_IDLE] | c.host_need);
    r.lcd     = t[`MIG_B_LCD_EN];
    return r;
  endfunction

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] e);
    check_count++;
    if (seen !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, seen);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    we    <= 1'b1;
    addr  <= a[7:0];
    wdata <= d;
    @(posedge ref_clk);
    we    <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string n);
    @(posedge ref_clk);
    re   <= 1'b1;
    addr <= a[7:0];
    @(posedge ref_clk);
    re   <= 1'b0;
    #1;
    chk(n, rdata_q, e);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    we = 1'b0;
    re = 1'b0;
    cond = '0;
    num_errors = 0;
    check_count = 0;
    void'($urandom(32'h4C11));
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`MIG_OFS_ONE, `MIG_RST_ONE, "one_reset");
    rd(`MIG_OFS_TWO, `MIG_RST_TWO, "two_reset");
    // Reserved bits set on purpose; only implemented fields may stick
    wr(`MIG_OFS_ONE, 32'hFFFF_FFFF);
    wr(`MIG_OFS_TWO, 32'hFFFF_FFFF);
    wr(32'h0000_000C, 32'hFFFF_FFFF);
    rd(`MIG_OFS_ONE, `MIG_MASK_ONE, "one_reserved");
    rd(`MIG_OFS_TWO, `MIG_MASK_TWO, "two_reserved");
    rd(32'h0000_000C, 32'h0, "unmapped");
    // Exhaustive conditions in the first 128 passes, second register random from pass 64, then random registers and conditions
    for (int i = 0; i < 400; i++) begin
      if (i % 16 == 0) begin
        one_m = (i < 128) ? 32'hFFFF_FFFF : $urandom;
        two_m = (i < 64) ? 32'hFFFF_FFFF : $urandom;
        wr(`MIG_OFS_ONE, one_m);
        wr(`MIG_OFS_TWO, two_m);
      end
      @(posedge ref_clk);
      cond <= (i < 128) ? migate_cond_t'(i[6:0]) : migate_cond_t'(7'($urandom));
      repeat (2) @(posedge ref_clk);
      #1;
      exp_r  = exp_run(one_m, two_m, cond);
      exp_v  = {22'h0, exp_r};
      seen_v = {22'h0, run_q};
      per_e  = one_m[`MIG_B_PER_IDLE] & cond.core_idle & !cond.tc_active;
      chk("run", seen_v, exp_v);
      chk("run_if", seen_v & 32'h3C0, exp_v & 32'h3C0);
      chk("run_ref", seen_v & 32'h030, exp_v & 32'h030);
      chk("run_pll", seen_v & 32'h009, exp_v & 32'h009);
      chk("run_tim", seen_v & 32'h006, exp_v & 32'h006);
      chk("per_idle_req", {31'h0, per_idle_req_q}, {31'h0, per_e});
      if (i % 8 == 0) begin
        rd(`MIG_OFS_STAT, exp_v, "status");
        rd(`MIG_OFS_TWO, two_m & `MIG_MASK_TWO, "two_readback");
      end
    end
    // Low clock enable must hold every register, even against a write
    @(posedge ref_clk);
    ce   <= 1'b0;
    cond <= migate_cond_t'(~cond);
    wr(`MIG_OFS_TWO, ~two_m);
    @(posedge ref_clk);
    #1;
    chk("ce_freeze", {22'h0, run_q}, seen_v);
    chk("ce_freeze_req", {31'h0, per_idle_req_q}, {31'h0, per_e});
    @(posedge ref_clk);
    ce <= 1'b1;
    rd(`MIG_OFS_TWO, two_m & `MIG_MASK_TWO, "ce_no_write");
    // Second reset in mid-run: clocks held off, registers back at reset values
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("reset_run", {22'h0, run_q}, 32'h0);
    chk("reset_req", {31'h0, per_idle_req_q}, 32'h0);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`MIG_OFS_ONE, `MIG_RST_ONE, "one_rereset");
    rd(`MIG_OFS_TWO, `MIG_RST_TWO, "two_rereset");
    exp_v = {22'h0, exp_run(`MIG_RST_ONE, `MIG_RST_TWO, cond)};
    chk("run_after_reset", {22'h0, run_q}, exp_v);
    print_verdict();
  end
endmodule
`default_nettype wire
